// [scs_pkg.sv]
/*
 * Constants and types shared by the serial control slave.
 * Assumes a single 100 MHz crystal-derived clock for the whole slave.
 */
`default_nettype none

package scs_pkg;

    ////////////////////////////////////////////////////////////////////////
    // bus addressing
    localparam logic [6:0] DEV_ADDR   = 7'h36;
    localparam logic [7:0] APPEND_SUB = 8'hfe;
    // subaddresses at or above this base belong to the processing core
    localparam logic [7:0] SPC_BASE   = 8'h20;
    localparam int         SPC_BYTES  = 4;

    ////////////////////////////////////////////////////////////////////////
    // timing: the fast bus period must span several system clocks
    localparam int CLOCK_MHZ      = 100;
    localparam int STD_RATE_KHZ   = 100;
    localparam int FAST_RATE_KHZ  = 400;
    localparam int FAST_PERIOD_CYC = (CLOCK_MHZ * 1000) / FAST_RATE_KHZ;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0]  SUB_RESET  = 8'h00;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // protocol engine states
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h0,
        ST_ADDR  = 4'h1,
        ST_ACK   = 4'h2,
        ST_SUB   = 4'h3,
        ST_WDATA = 4'h4,
        ST_RLOAD = 4'h5,
        ST_RDATA = 4'h6,
        ST_RACK  = 4'h7
    } scs_state_e;

    // subaddress decode used by the sub path; the write path uses spc_mode_reg
    function automatic logic scs_is_spc(input logic [7:0] sub);
        scs_is_spc = (sub >= SPC_BASE) && (sub != APPEND_SUB);
    endfunction

endpackage

`default_nettype wire

// [scs_line_if.sv]
/*
 * Line events passed from the pin front end to the protocol engine.
 * Assumes both ends run on the same system clock.
 */
`default_nettype none

interface scs_line_if;
    logic scl_rise;
    logic scl_fall;
    logic sda;
    logic start;
    logic stop;

    modport frontend (
        output scl_rise,
        output scl_fall,
        output sda,
        output start,
        output stop
    );

    modport engine (
        input scl_rise,
        input scl_fall,
        input sda,
        input start,
        input stop
    );
endinterface

`default_nettype wire

// [scs_line_sync.sv]
/*
 * Pin front end: synchronises the bus clock and data pins and finds
 * clock edges, start and stop conditions.
 * Assumes pins are asynchronous to i_clock and idle high.
 */
`default_nettype none

module scs_line_sync (
    // clock and reset
    input  wire logic     i_clock,
    input  wire logic     i_rstn,
    // bus pins
    input  wire logic     i_scl,
    input  wire logic     i_sda,
    // events
    scs_line_if.frontend  ln
);

    logic scl_s1_reg;
    logic scl_s2_reg;
    logic scl_d_reg;
    logic sda_s1_reg;
    logic sda_s2_reg;
    logic sda_d_reg;

    ////////////////////////////////////////////////////////////////////////
    // two flops before use; the third only delays for edge finding
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            scl_s1_reg <= 1'b1;
            scl_s2_reg <= 1'b1;
            scl_d_reg  <= 1'b1;
            sda_s1_reg <= 1'b1;
            sda_s2_reg <= 1'b1;
            sda_d_reg  <= 1'b1;
        end else begin
            scl_s1_reg <= i_scl;
            scl_s2_reg <= scl_s1_reg;
            scl_d_reg  <= scl_s2_reg;
            sda_s1_reg <= i_sda;
            sda_s2_reg <= sda_s1_reg;
            sda_d_reg  <= sda_s2_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign ln.scl_rise = scl_s2_reg & ~scl_d_reg;
    assign ln.scl_fall = ~scl_s2_reg & scl_d_reg;
    assign ln.sda      = sda_s2_reg;
    assign ln.start    = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
    assign ln.stop     = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;

endmodule

`default_nettype wire

// [scs_slave.sv]
/*
 * Serial control slave: two-wire bus slave that reaches general byte
 * registers and the processing core's coefficient registers.
 * Assumes a crystal-derived i_clock and a byte register file that
 * answers i_reg_rdata combinationally from o_reg_addr.
 */
// Functional notes
// - The slave answers only device address 0x36 and ignores all others.
// - It runs at 100 kHz and 400 kHz and never stretches the bus clock.
// - It runs from the crystal clock alone, without the audio master clock.
// - General and status registers accept single and multi-byte reads and writes.
// - Processing core registers take multi-byte writes in four-byte units.
// - An incremental write is address, direction, subaddress and 4n data bytes.
// - A large write resumes across blocks unless a core subaddress is written in between.
// - There is no split read; a register is read within one transaction.
`default_nettype none

module scs_slave
    import scs_pkg::*;
(
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rstn,
    // bus pins; data is open drain
    input  wire logic        i_scl,
    input  wire logic        i_sda,
    output logic             o_sda,
    output logic             o_sda_oe_n,
    // general register port
    output logic [7:0]       o_reg_addr,
    input  wire logic [7:0]  i_reg_rdata,
    output logic             o_reg_rd,
    output logic             o_reg_wr,
    output logic [7:0]       o_reg_waddr,
    output logic [7:0]       o_reg_wdata,
    // processing core word port
    output logic             o_spc_wr,
    output logic [7:0]       o_spc_addr,
    output logic [7:0]       o_spc_word,
    output logic [31:0]      o_spc_data,
    // status
    output logic             o_busy
);
    import scs_pkg::*;
    scs_line_if ln ();
    // sole clock is the crystal one, so no master clock is needed
    scs_line_sync u_sync (
        .i_clock (i_clock),
        .i_rstn  (i_rstn),
        .i_scl   (i_scl),
        .i_sda   (i_sda),
        .ln      (ln)
    );
    ////////////////////////////////////////////////////////////////////////
    scs_state_e  state_reg,    state_next;
    scs_state_e  after_reg,    after_next;
    logic        ack_on_reg,   ack_on_next;
    logic [2:0]  bit_cnt_reg,  bit_cnt_next;
    logic [7:0]  shift_reg,    shift_next;
    logic [7:0]  sub_reg,      sub_next;
    logic        oe_n_reg,     oe_n_next;
    logic        spc_mode_reg, spc_mode_next;
    logic [1:0]  bidx_reg,     bidx_next;
    logic [31:0] word_reg,     word_next;
    logic [7:0]  spc_sub_reg,  spc_sub_next;
    logic [7:0]  spc_idx_reg,  spc_idx_next;
    logic [7:0]  spc_wout_reg, spc_wout_next;
    logic [31:0] spc_data_reg, spc_data_next;
    logic        spc_wr_reg,   spc_wr_next;
    logic        rd_reg,       rd_next;
    logic        wr_reg,       wr_next;
    logic [7:0]  waddr_reg,    waddr_next;
    logic [7:0]  wdata_reg,    wdata_next;
    wire  [7:0]  byte_in   = {shift_reg[6:0], ln.sda};
    wire         last_bit  = (bit_cnt_reg == 3'd7);
    wire         addr_hit  = (byte_in[7:1] == DEV_ADDR);
    wire         sub_app   = (byte_in == APPEND_SUB);
    wire         sub_spc   = scs_is_spc(byte_in);
    wire         word_done = (bidx_reg == 2'(SPC_BYTES - 1));
    ////////////////////////////////////////////////////////////////////////
    // edges come from 100 MHz sampling, so a 400 kHz bus needs no stretch
    always_comb begin
        state_next    = state_reg;
        after_next    = after_reg;
        ack_on_next   = ack_on_reg;
        bit_cnt_next  = bit_cnt_reg;
        shift_next    = shift_reg;
        sub_next      = sub_reg;
        oe_n_next     = oe_n_reg;
        spc_mode_next = spc_mode_reg;
        bidx_next     = bidx_reg;
        word_next     = word_reg;
        spc_sub_next  = spc_sub_reg;
        spc_idx_next  = spc_idx_reg;
        spc_wout_next = spc_wout_reg;
        spc_data_next = spc_data_reg;
        spc_wr_next   = 1'b0;
        rd_next       = 1'b0;
        wr_next       = 1'b0;
        waddr_next    = waddr_reg;
        wdata_next    = wdata_reg;
        if (ln.start) begin
            state_next   = ST_ADDR;
            bit_cnt_next = 3'd0;
            oe_n_next    = 1'b1;
            // a partial word is dropped; blocks are whole words
            bidx_next    = 2'd0;
        end else if (ln.stop) begin
            state_next = ST_IDLE;
            oe_n_next  = 1'b1;
        end else begin
            unique case (state_reg)
                ST_IDLE: ;
                ST_ADDR: begin
                    if (ln.scl_rise) begin
                        shift_next   = byte_in;
                        bit_cnt_next = bit_cnt_reg + 3'd1;
                        if (last_bit) begin
                            if (addr_hit) begin
                                state_next  = ST_ACK;
                                ack_on_next = 1'b0;
                                after_next  = byte_in[0] ? ST_RLOAD : ST_SUB;
                            end else begin
                                state_next = ST_IDLE;
                            end
                        end
                    end
                end
                ST_ACK: begin
                    if (ln.scl_fall) begin
                        if (!ack_on_reg) begin
                            ack_on_next = 1'b1;
                            oe_n_next   = 1'b0;
                        end else begin
                            ack_on_next  = 1'b0;
                            bit_cnt_next = 3'd0;
                            if (after_reg == ST_RLOAD) begin
                                shift_next = i_reg_rdata;
                                oe_n_next  = i_reg_rdata[7];
                                rd_next    = 1'b1;
                                state_next = ST_RDATA;
                            end else begin
                                oe_n_next  = 1'b1;
                                state_next = after_reg;
                            end
                        end
                    end
                end
                ST_SUB: begin
                    if (ln.scl_rise) begin
                        shift_next   = byte_in;
                        bit_cnt_next = bit_cnt_reg + 3'd1;
                        if (last_bit) begin
                            sub_next      = byte_in;
                            spc_mode_next = sub_app | sub_spc;
                            // new target restarts the count; append goes on
                            if (sub_spc) begin
                                spc_sub_next = byte_in;
                                spc_idx_next = 8'h00;
                            end
                            after_next  = ST_WDATA;
                            ack_on_next = 1'b0;
                            state_next  = ST_ACK;
                        end
                    end
                end
                ST_WDATA: begin
                    if (ln.scl_rise) begin
                        shift_next   = byte_in;
                        bit_cnt_next = bit_cnt_reg + 3'd1;
                        if (last_bit) begin
                            if (spc_mode_reg) begin
                                word_next = {word_reg[23:0], byte_in};
                                bidx_next = bidx_reg + 2'd1;
                                if (word_done) begin
                                    spc_wr_next   = 1'b1;
                                    spc_data_next = {word_reg[23:0], byte_in};
                                    spc_wout_next = spc_idx_reg;
                                    spc_idx_next  = spc_idx_reg + 8'd1;
                                end
                            end else begin
                                wr_next    = 1'b1;
                                waddr_next = sub_reg;
                                wdata_next = byte_in;
                                sub_next   = sub_reg + 8'd1;
                            end
                            after_next  = ST_WDATA;
                            ack_on_next = 1'b0;
                            state_next  = ST_ACK;
                        end
                    end
                end
                ST_RDATA: begin
                    if (ln.scl_fall) begin
                        shift_next = {shift_reg[6:0], 1'b0};
                        oe_n_next  = shift_reg[6];
                    end
                    if (ln.scl_rise) begin
                        bit_cnt_next = bit_cnt_reg + 3'd1;
                        if (last_bit) begin
                            state_next = ST_RACK;
                        end
                    end
                end
                ST_RACK: begin
                    if (ln.scl_fall) begin
                        oe_n_next = 1'b1;
                    end
                    if (ln.scl_rise) begin
                        // master nack ends the read; no resume later
                        if (!ln.sda) begin
                            sub_next   = sub_reg + 8'd1;
                            state_next = ST_RLOAD;
                        end else begin
                            state_next = ST_IDLE;
                        end
                    end
                end
                ST_RLOAD: begin
                    if (ln.scl_fall) begin
                        shift_next   = i_reg_rdata;
                        oe_n_next    = i_reg_rdata[7];
                        rd_next      = 1'b1;
                        bit_cnt_next = 3'd0;
                        state_next   = ST_RDATA;
                    end
                end
                default: begin
                    state_next = ST_IDLE;
                    oe_n_next  = 1'b1;
                end
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            state_reg    <= ST_IDLE;
            after_reg    <= ST_IDLE;
            ack_on_reg   <= 1'b0;
            bit_cnt_reg  <= 3'd0;
            shift_reg    <= SUB_RESET;
            sub_reg      <= SUB_RESET;
            oe_n_reg     <= 1'b1;
            spc_mode_reg <= 1'b0;
            bidx_reg     <= 2'd0;
            word_reg     <= WORD_RESET;
            spc_sub_reg  <= SUB_RESET;
            spc_idx_reg  <= SUB_RESET;
            spc_wout_reg <= SUB_RESET;
            spc_data_reg <= WORD_RESET;
            spc_wr_reg   <= 1'b0;
            rd_reg       <= 1'b0;
            wr_reg       <= 1'b0;
            waddr_reg    <= SUB_RESET;
            wdata_reg    <= SUB_RESET;
        end else begin
            state_reg    <= state_next;
            after_reg    <= after_next;
            ack_on_reg   <= ack_on_next;
            bit_cnt_reg  <= bit_cnt_next;
            shift_reg    <= shift_next;
            sub_reg      <= sub_next;
            oe_n_reg     <= oe_n_next;
            spc_mode_reg <= spc_mode_next;
            bidx_reg     <= bidx_next;
            word_reg     <= word_next;
            spc_sub_reg  <= spc_sub_next;
            spc_idx_reg  <= spc_idx_next;
            spc_wout_reg <= spc_wout_next;
            spc_data_reg <= spc_data_next;
            spc_wr_reg   <= spc_wr_next;
            rd_reg       <= rd_next;
            wr_reg       <= wr_next;
            waddr_reg    <= waddr_next;
            wdata_reg    <= wdata_next;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // open drain: only ever pulls low
    assign o_sda       = 1'b0;
    assign o_sda_oe_n  = oe_n_reg;
    assign o_reg_addr  = sub_reg;
    assign o_reg_rd    = rd_reg;
    assign o_reg_wr    = wr_reg;
    assign o_reg_waddr = waddr_reg;
    assign o_reg_wdata = wdata_reg;
    assign o_spc_wr    = spc_wr_reg;
    assign o_spc_addr  = spc_sub_reg;
    assign o_spc_word  = spc_wout_reg;
    assign o_spc_data  = spc_data_reg;
    assign o_busy      = (state_reg != ST_IDLE);
endmodule

`default_nettype wire

// [scs_slave_assertions.sv]
/* Port assertions for the serial control slave, bound to scs_slave.
   Assumes bus clock low and high phases of at least four clocks. */
`default_nettype none

module scs_slave_assertions
    import scs_pkg::*;
(
    // clock and reset
    input wire logic        i_clock,
    input wire logic        i_rstn,
    // bus pins
    input wire logic        i_scl,
    input wire logic        i_sda,
    input wire logic        o_sda,
    input wire logic        o_sda_oe_n,
    // register ports
    input wire logic [7:0]  o_reg_addr,
    input wire logic [7:0]  i_reg_rdata,
    input wire logic        o_reg_rd,
    input wire logic        o_reg_wr,
    input wire logic [7:0]  o_reg_waddr,
    input wire logic [7:0]  o_reg_wdata,
    input wire logic        o_spc_wr,
    input wire logic [7:0]  o_spc_addr,
    input wire logic [7:0]  o_spc_word,
    input wire logic [31:0] o_spc_data,
    // status
    input wire logic        o_busy
);
    // four bytes of nine bits at eight clocks each, less a margin
    localparam int MIN_SPC_GAP = 280;
    logic [15:0] gap_reg;
    logic [7:0]  word_reg;
    logic [7:0]  tgt_reg;

    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rstn);

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            gap_reg  <= 16'hffff;
            word_reg <= 8'h00;
            tgt_reg  <= 8'h00;
        end else if (o_spc_wr) begin
            gap_reg  <= 16'h0000;
            word_reg <= o_spc_word;
            tgt_reg  <= o_spc_addr;
        end else if (gap_reg != 16'hffff) begin
            gap_reg  <= gap_reg + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sequence s_low8;  (!o_sda_oe_n)[*8]; endsequence
    sequence s_high8; o_sda_oe_n[*8]; endsequence
    property p_ack_busy; !o_sda_oe_n |-> o_busy; endproperty
    property p_drive_stands; $fell(o_sda_oe_n) |-> s_low8; endproperty
    property p_release_stands; $rose(o_sda_oe_n) |-> s_high8; endproperty
    property p_wr_held;
        o_reg_wr |=> (!o_reg_wr && $stable(o_reg_waddr)
                      && $stable(o_reg_wdata))[*8];
    endproperty
    property p_wr_general; o_reg_wr |-> o_reg_waddr < SPC_BASE && !o_spc_wr;
    endproperty
    property p_ptr_step;
        o_reg_wr |-> ##[0:2] (o_reg_addr == o_reg_waddr + 8'h01);
    endproperty
    property p_spc_gap; o_spc_wr |-> gap_reg >= MIN_SPC_GAP; endproperty
    property p_spc_target;
        o_spc_wr |-> o_spc_addr != APPEND_SUB
                     && (o_spc_addr >= SPC_BASE || o_spc_addr == 8'h00);
    endproperty
    property p_spc_resume;
        o_spc_wr && o_spc_word != 8'h00 |->
            o_spc_word == word_reg + 8'h01 && o_spc_addr == tgt_reg;
    endproperty
    property p_rd_in_txn; o_reg_rd |-> o_busy && !o_reg_wr; endproperty

    a_ack_busy: assert property (p_ack_busy)
        else $error("data line driven while idle");
    a_drive_stands: assert property (p_drive_stands)
        else $error("driven low bit too short");
    a_release_stands: assert property (p_release_stands)
        else $error("released bit too short");
    a_wr_held: assert property (p_wr_held)
        else $error("byte write not held");
    a_wr_general: assert property (p_wr_general)
        else $error("byte write outside general range");
    a_ptr_step: assert property (p_ptr_step)
        else $error("pointer did not step");
    a_spc_gap: assert property (p_spc_gap)
        else $error("core word shorter than four bytes");
    a_spc_target: assert property (p_spc_target)
        else $error("core word to bad target");
    a_spc_resume: assert property (p_spc_resume)
        else $error("append did not resume");
    a_rd_in_txn: assert property (p_rd_in_txn)
        else $error("read outside transaction");
endmodule

bind scs_slave scs_slave_assertions chk_u (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_scl(i_scl), .i_sda(i_sda),
    .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n), .o_reg_addr(o_reg_addr),
    .i_reg_rdata(i_reg_rdata), .o_reg_rd(o_reg_rd), .o_reg_wr(o_reg_wr),
    .o_reg_waddr(o_reg_waddr), .o_reg_wdata(o_reg_wdata),
    .o_spc_wr(o_spc_wr), .o_spc_addr(o_spc_addr), .o_spc_word(o_spc_word),
    .o_spc_data(o_spc_data), .o_busy(o_busy)
);

`default_nettype wire

// [scs_master_model.sv]
/* Bus master model: drives the bus clock and open-drain data.
   Assumes a pulled-up data wire resolved by the bench. */
`default_nettype none

module scs_master_model (
    // pacing clock
    input  wire logic i_clock,
    // bus lines; o_sda high means released
    input  wire logic i_sda,
    output var logic  o_scl,
    output var logic  o_sda
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge i_clock);
    endtask

    // 80 ns bit: data moves mid-low, sampled mid-high
    task automatic bit_cycle(input logic b, output logic s);
        o_scl = 1'b0;
        wait_clk(2);
        o_sda = b;
        wait_clk(2);
        o_scl = 1'b1;
        wait_clk(2);
        s = i_sda;
        wait_clk(2);
    endtask

    task automatic start();
        o_scl = 1'b0;
        wait_clk(2);
        o_sda = 1'b1;
        wait_clk(2);
        o_scl = 1'b1;
        wait_clk(4);
        o_sda = 1'b0;
        wait_clk(4);
    endtask

    // clock is left high after stop: it stands still between frames
    task automatic stop();
        o_scl = 1'b0;
        wait_clk(2);
        o_sda = 1'b0;
        wait_clk(2);
        o_scl = 1'b1;
        wait_clk(4);
        o_sda = 1'b1;
        wait_clk(4);
    endtask

    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_cycle(b[i], s);
        bit_cycle(1'b1, ack);
    endtask

    task automatic get_byte(output logic [7:0] b, input logic nack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, s);
            b[i] = s;
        end
        bit_cycle(nack, s);
    endtask
endmodule

`default_nettype wire

// [scs_slave_test.sv]
/* Self-checking bench for the serial control slave.
   Assumes the master model and a byte register file on the far side. */
`default_nettype none

module scs_slave_test;
    timeunit 1ns;
    timeprecision 1ps;
    import scs_pkg::*;

    typedef struct packed {
        logic        spc;
        logic [7:0]  addr;
        logic [7:0]  idx;
        logic [31:0] data;
    } scs_note_s;

    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        scl, m_sda, sda_wire, o_sda, o_sda_oe_n;
    logic        o_reg_rd, o_reg_wr, o_spc_wr, o_busy;
    logic [7:0]  o_reg_addr, o_reg_waddr, o_reg_wdata, o_spc_addr, o_spc_word;
    logic [31:0] o_spc_data;
    logic [7:0]  regs [256];
    logic [7:0]  exp_mem [256];
    logic [7:0]  tgt = 8'h00;
    logic [7:0]  idx = 8'h00;
    logic [16:0] lfsr = 17'h14d45;
    scs_note_s   notes [$];
    scs_note_s   note;
    int          error_cnt = 0;
    int          n_tests = 0;
    int          rd_cnt = 0;
    int          rd_exp = 0;

    always #5 clock = ~clock;
    assign sda_wire = m_sda & (o_sda_oe_n | o_sda);

    scs_slave dut_u (
        .i_clock(clock), .i_rstn(rst_n), .i_scl(scl), .i_sda(sda_wire),
        .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n), .o_reg_addr(o_reg_addr),
        .i_reg_rdata(regs[o_reg_addr]), .o_reg_rd(o_reg_rd),
        .o_reg_wr(o_reg_wr), .o_reg_waddr(o_reg_waddr),
        .o_reg_wdata(o_reg_wdata), .o_spc_wr(o_spc_wr),
        .o_spc_addr(o_spc_addr), .o_spc_word(o_spc_word),
        .o_spc_data(o_spc_data), .o_busy(o_busy)
    );
    scs_master_model m_u (
        .i_clock(clock), .i_sda(sda_wire), .o_scl(scl), .o_sda(m_sda)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    function automatic logic [7:0] rand_byte();
        lfsr = {lfsr[15:0], lfsr[16] ^ lfsr[13]};
        return lfsr[7:0];
    endfunction

    // notes are queued before the byte that will produce them
    task automatic wr_txn(input logic [6:0] dev, input logic [7:0] sub,
                          input int n);
        logic [7:0]  b;
        logic        ack;
        logic [31:0] word;
        m_u.start();
        m_u.put_byte({dev, 1'b0}, ack);
        chk("address ack", 32'(ack), 32'(dev != DEV_ADDR));
        if (ack === 1'b0) begin
            m_u.put_byte(sub, ack);
            if (sub >= SPC_BASE && sub != APPEND_SUB) begin
                tgt = sub;
                idx = 8'h00;
            end
            for (int i = 0; i < n; i++) begin
                b = rand_byte();
                word = {word[23:0], b};
                if (sub < SPC_BASE) begin
                    exp_mem[sub + 8'(i)] = b;
                    notes.push_back('{1'b0, sub + 8'(i), 8'h00, 32'(b)});
                end else if (i % 4 == 3) begin
                    notes.push_back('{1'b1, tgt, idx, word});
                    idx++;
                end
                m_u.put_byte(b, ack);
                chk("data ack", 32'(ack), 32'h0);
            end
        end
        m_u.stop();
    endtask

    task automatic rd_txn(input logic [7:0] sub, input int n);
        logic [7:0] b;
        logic       ack;
        rd_exp += n;
        m_u.start();
        m_u.put_byte({DEV_ADDR, 1'b0}, ack);
        m_u.put_byte(sub, ack);
        m_u.start();
        m_u.put_byte({DEV_ADDR, 1'b1}, ack);
        chk("read ack", 32'(ack), 32'h0);
        for (int i = 0; i < n; i++) begin
            m_u.get_byte(b, i == n - 1);
            chk("read data", 32'(b), 32'(exp_mem[sub + 8'(i)]));
        end
        chk("read strobes", 32'(rd_cnt), 32'(rd_exp));
        m_u.stop();
    endtask

    ////////////////////////////////////////////////////////////////////////
    always @(negedge clock) begin
        if (o_reg_wr === 1'b1 || o_spc_wr === 1'b1) begin
            if (notes.size() == 0) begin
                chk("unexpected write", 32'h1, 32'h0);
            end else begin
                note = notes.pop_front();
                chk("write kind", 32'(o_spc_wr), 32'(note.spc));
                if (note.spc) begin
                    chk("core target", 32'(o_spc_addr), 32'(note.addr));
                    chk("core word", 32'(o_spc_word), 32'(note.idx));
                    chk("core data", o_spc_data, note.data);
                end else begin
                    chk("byte addr", 32'(o_reg_waddr), 32'(note.addr));
                    chk("byte data", 32'(o_reg_wdata), note.data);
                end
            end
        end
        if (o_reg_wr === 1'b1) regs[o_reg_waddr] <= o_reg_wdata;
        if (o_reg_rd === 1'b1) rd_cnt++;
    end

    initial begin
        logic [7:0] b;
        foreach (regs[i]) regs[i] = 8'h00;
        repeat (8) @(negedge clock);
        rst_n = 1'b1;
        @(negedge clock);
        chk("idle busy", 32'(o_busy), 32'h0);
        chk("idle release", 32'(o_sda_oe_n), 32'h1);
        wr_txn(DEV_ADDR, 8'h05, 3);
        rd_txn(8'h05, 3);
        wr_txn(7'h37, 8'h05, 2);
        wr_txn(DEV_ADDR, 8'h40, 4);
        // unrelated traffic between blocks of one large write
        wr_txn(DEV_ADDR, 8'h10, 1);
        rd_txn(8'h10, 1);
        wr_txn(DEV_ADDR, APPEND_SUB, 8);
        wr_txn(DEV_ADDR, 8'h60, 8);
        rst_n = 1'b0;
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        for (int k = 0; k < 4; k++) begin
            b = rand_byte();
            wr_txn(DEV_ADDR, b & 8'h1c, 3);
            rd_txn(b & 8'h1c, 3);
        end
        repeat (20) @(negedge clock);
        chk("notes left", 32'(notes.size()), 32'h0);
        test_done();
    end

    initial begin
        #500us;
        chk("watchdog", 32'h1, 32'h0);
        test_done();
    end
endmodule

`default_nettype wire
